// ==== hw/vcs_pkg.sv ====
// Shared constants, types and helpers of the video capture scaler block.
// Assumes a single 40 MHz clock domain and a 32-bit register bus.
package vcs_pkg;
   // ********************************************************
   // Widths and capture buffer size
   // ********************************************************
   localparam int DIM_W = 12;
   localparam int ADDR_W = 8;
   localparam int BUF_BYTES = 4096;
   localparam int WORD_BYTES = 4;
   localparam int BUF_WORDS = BUF_BYTES / WORD_BYTES;
   localparam int LVL_W = $clog2(BUF_WORDS + 1);
   // ********************************************************
   // Register offsets and fields
   // ********************************************************
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_IN_DIM = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_OUT_DIM = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_MASK = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_STATE = 8'h14;
   localparam int CTRL_EN_B = 0;
   localparam int CTRL_PRST_B = 1;
   localparam int CTRL_FRST_B = 2;
   localparam int DIM_W_LSB = 0;
   localparam int DIM_H_LSB = 16;
   localparam int EV_OVF_B = 0;
   localparam int EV_RSZ_B = 1;
   localparam int EV_FRM_B = 2;
   localparam int EV_N = 3;
   localparam int ST_OVF_B = 0;
   localparam int ST_SYN_B = 1;
   localparam int ST_FULL_B = 2;
   localparam int ST_LVL_LSB = 16;
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_IN_DIM = 32'h0004_0004;
   localparam logic [31:0] RST_OUT_DIM = 32'h0002_0002;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ********************************************************
   // State types
   // ********************************************************
   typedef enum logic [1:0] {SC_WAIT = 2'b00, SC_RUN = 2'b01, SC_SYN = 2'b11} vcs_sc_state_t;
   typedef enum logic {PA_PASS = 1'b0, PA_DROP = 1'b1} vcs_pa_state_t;
   // Bresenham step: {hit, next accumulator}
   function automatic logic [DIM_W:0] vcs_dda(input logic [DIM_W-1:0] acc,
                                               input logic [DIM_W-1:0] num,
                                               input logic [DIM_W-1:0] den);
      logic [DIM_W:0] sum;
      sum = {1'b0, acc} + {1'b0, num};
      if (sum >= {1'b0, den}) begin
         vcs_dda = {1'b1, DIM_W'(sum - {1'b0, den})};
      end else begin
         vcs_dda = {1'b0, sum[DIM_W-1:0]};
      end
   endfunction
   // Byte-lane merge of a register write
   function automatic logic [31:0] vcs_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         vcs_merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction
endpackage

// ==== hw/vcs_if.sv ====
// Carriers between the block's own modules: pixel stream and register access.
// Assumes all users share one clock.
interface vcs_pix_if #(parameter int PW = 24);
   logic valid;
   logic ready;
   logic sof;
   logic sol;
   logic [PW-1:0] data;
   modport src(output valid, sof, sol, data, input ready);
   modport snk(input valid, sof, sol, data, output ready);
endinterface

interface vcs_reg_if;
   logic wr_en;
   logic [vcs_pkg::ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic rd_en;
   logic [vcs_pkg::ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;
   modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
               input wr_err, rd_data, rd_err);
   modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface

// ==== hw/vcs_axil.sv ====
// AXI4-Lite slave front end: turns bus transfers into register strobes.
// Assumes the register side answers combinationally in the strobe cycle.
module vcs_axil (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Write channels
   input wire logic [vcs_pkg::ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // Read channels
   input wire logic [vcs_pkg::ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // Register side
   vcs_reg_if.bus rg
);
   logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
   logic [vcs_pkg::ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;
   wire aw_take = awvalid_i && awready_o;
   wire w_take = wvalid_i && wready_o;
   wire do_wr = (aw_hold_ff || aw_take) && (w_hold_ff || w_take);
   // Handshakes and strobes
   assign awready_o = !aw_hold_ff && !bvalid_ff;
   assign wready_o = !w_hold_ff && !bvalid_ff;
   assign arready_o = !rvalid_ff;
   assign rg.wr_en = do_wr;
   assign rg.wr_addr = aw_hold_ff ? awaddr_ff : awaddr_i;
   assign rg.wr_data = w_hold_ff ? wdata_ff : wdata_i;
   assign rg.wr_strb = w_hold_ff ? wstrb_ff : wstrb_i;
   assign rg.rd_en = arvalid_i && arready_o;
   assign rg.rd_addr = araddr_i;
   assign {bvalid_o, bresp_o, rvalid_o, rresp_o, rdata_o} =
      {bvalid_ff, bresp_ff, rvalid_ff, rresp_ff, rdata_ff};
   // Write path: either channel may come first
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {aw_hold_ff, w_hold_ff, bvalid_ff} <= 3'b000;
         awaddr_ff <= '0;
         wdata_ff <= '0;
         wstrb_ff <= '0;
         bresp_ff <= vcs_pkg::RESP_OKAY;
      end else begin
         aw_hold_ff <= !do_wr && (aw_hold_ff || aw_take);
         w_hold_ff <= !do_wr && (w_hold_ff || w_take);
         if (aw_take) awaddr_ff <= awaddr_i;
         if (w_take) begin
            wdata_ff <= wdata_i;
            wstrb_ff <= wstrb_i;
         end
         if (do_wr) bresp_ff <= rg.wr_err ? vcs_pkg::RESP_SLVERR : vcs_pkg::RESP_OKAY;
         bvalid_ff <= do_wr || (bvalid_ff && !bready_i);
      end
   end
   // Read path: data captured in the address cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rvalid_ff <= 1'b0;
         rdata_ff <= '0;
         rresp_ff <= vcs_pkg::RESP_OKAY;
      end else begin
         if (rg.rd_en) begin
            rdata_ff <= rg.rd_data;
            rresp_ff <= rg.rd_err ? vcs_pkg::RESP_SLVERR : vcs_pkg::RESP_OKAY;
         end
         rvalid_ff <= rg.rd_en || (rvalid_ff && !rready_i);
      end
   end
endmodule

// ==== hw/vcs_parser.sv ====
// Capture input parser: synchronises the video pins and feeds the scaler.
// Assumes the source holds each pin state for at least one clock period.
module vcs_parser #(parameter int PW = 24) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clr_i,
   // Capture buffer has room
   input wire logic space_i,
   // Video pins
   input wire logic vid_de_i,
   input wire logic vid_ls_i,
   input wire logic vid_fs_i,
   input wire logic [PW-1:0] vid_pix_i,
   // Stream to scaler and status
   vcs_pix_if.src pix,
   output logic ovf_o,
   output logic ovf_evt_o
);
   if (PW < 1 || PW > 32) begin : g_chk
      $error("vcs_parser: PW out of range");
   end
   logic [PW+2:0] s1_ff, s2_ff, out_ff;
   logic valid_ff;
   vcs_pkg::vcs_pa_state_t st_ff, nxt_st;
   wire p = s2_ff[PW];
   wire p_ls = s2_ff[PW+1] || s2_ff[PW+2];
   wire out_free = !valid_ff || pix.ready;
   wire pass_ok = p && out_free && space_i;
   // Drop mode takes again only from a line start [R12]
   wire load = (st_ff == vcs_pkg::PA_PASS) ? pass_ok : (pass_ok && p_ls);
   // Pixel that cannot be taken starts an overflow [R4] [R7]
   assign ovf_evt_o = (st_ff == vcs_pkg::PA_PASS) && p && !pass_ok;
   assign ovf_o = (st_ff == vcs_pkg::PA_DROP);
   assign pix.valid = valid_ff;
   assign {pix.sof, pix.sol, pix.data} = {out_ff[PW+2], out_ff[PW+1], out_ff[PW-1:0]};
   // Overflow state: discard until space and a new line [R5] [R12]
   always_comb begin
      nxt_st = st_ff;
      if (clr_i) nxt_st = vcs_pkg::PA_PASS;
      else if (ovf_evt_o) nxt_st = vcs_pkg::PA_DROP;
      else if (st_ff == vcs_pkg::PA_DROP && load) nxt_st = vcs_pkg::PA_PASS;
   end
   // Pin synchroniser and output register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
         out_ff <= '0;
         valid_ff <= 1'b0;
         st_ff <= vcs_pkg::PA_PASS;
      end else begin
         s1_ff <= {vid_fs_i, vid_ls_i, vid_de_i, vid_pix_i};
         s2_ff <= s1_ff;
         st_ff <= nxt_st;
         if (load) out_ff <= s2_ff;
         valid_ff <= !clr_i && (load || (valid_ff && !pix.ready));
      end
   end
endmodule

// ==== hw/vcs_top.sv ====
// Video capture path: parser, inline downscaler and capture buffer level.
// Assumes an AXI4-Lite master and a DMA engine that drains one word per pulse.
//
// Contract
// R1 - Scaler holds separate input and output height and width settings.
// R2 - Wrongly sized input still yields exactly the configured output frame.
// R3 - While synthesizing missing output, scaler requests no data from parser.
// R4 - Capture buffer holds 4k bytes; when full, parser enters overflow.
// R5 - In overflow, parser discards pixels and lines, shrinking the frame.
// R6 - Missing output is generated at full internal rate, unpaced by video.
// R7 - Video refused while scaler withholds requests causes further overflow.
// R8 - Software disables the port, then asserts the port reset bit.
// R9 - Software then asserts parser FIFO reset before posting abort descriptors.
// R10 - With both resets held, software posts aborts for all channels.
// R11 - After aborts complete, release port reset, FIFO reset, then restart.
// R12 - Overflow ends when buffer has space, resuming at next line start.
module vcs_top #(parameter int PIX_W = 24) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // AXI4-Lite write channels
   input wire logic [vcs_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // AXI4-Lite read channels
   input wire logic [vcs_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // External video pins
   input wire logic [PIX_W-1:0] VID_PIX_I,
   input wire logic VID_DE_I,
   input wire logic VID_LS_I,
   input wire logic VID_FS_I,
   // Capture buffer write side and drain
   output logic [PIX_W-1:0] CAP_DATA_O,
   output logic CAP_VALID_O,
   output logic CAP_SOF_O,
   input wire logic DMA_DRAIN_I,
   // Interrupt
   output logic IRQ_O
);
   localparam int DW = vcs_pkg::DIM_W;
   localparam int LW = vcs_pkg::LVL_W;

   if (PIX_W < 1 || PIX_W > 32) begin : g_chk
      $error("vcs_top: PIX_W out of range");
   end

   // ********************************************************
   // Declarations
   // ********************************************************
   vcs_pix_if #(.PW(PIX_W)) pix_if();
   vcs_reg_if reg_if();
   logic [31:0] ctrl_ff, in_dim_ff, out_dim_ff;
   logic [vcs_pkg::EV_N-1:0] stat_ff, mask_ff, nxt_stat, ev;
   logic [LW-1:0] lvl_ff, nxt_lvl;
   vcs_pkg::vcs_sc_state_t st_ff, nxt_st;
   logic [DW-1:0] ix_ff, iy_ff, hacc_ff, vacc_ff, ox_ff, oy_ff;
   logic [DW-1:0] nxt_ix, nxt_iy, nxt_hacc, nxt_vacc, nxt_ox, nxt_oy;
   logic vsel_ff, nxt_vsel;
   logic [PIX_W-1:0] last_ff, nxt_last, cap_data_ff, nxt_cap_data;
   logic cap_valid_ff, nxt_cap_valid, cap_sof_ff, nxt_cap_sof;
   logic run_pix, rsz_evt, frm_evt;
   logic ovf, ovf_evt;

   // ********************************************************
   // Control decode
   // ********************************************************
   // Input and output dimensions held apart [R1]
   wire [DW-1:0] in_w = in_dim_ff[vcs_pkg::DIM_W_LSB +: DW];
   wire [DW-1:0] in_h = in_dim_ff[vcs_pkg::DIM_H_LSB +: DW];
   wire [DW-1:0] out_w = out_dim_ff[vcs_pkg::DIM_W_LSB +: DW];
   wire [DW-1:0] out_h = out_dim_ff[vcs_pkg::DIM_H_LSB +: DW];
   wire port_en = ctrl_ff[vcs_pkg::CTRL_EN_B];
   wire port_rst = ctrl_ff[vcs_pkg::CTRL_PRST_B];
   wire fifo_rst = ctrl_ff[vcs_pkg::CTRL_FRST_B];
   // Port reset or disable stops the scaler; FIFO reset also the parser [R8] [R9]
   wire sc_clr = port_rst || !port_en;
   wire pa_clr = sc_clr || fifo_rst;
   wire buf_free = (lvl_ff < LW'(vcs_pkg::BUF_WORDS));

   // ********************************************************
   // Parser and bus front end
   // ********************************************************
   vcs_parser #(.PW(PIX_W)) u_parser (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .clr_i(pa_clr),
      .space_i(buf_free),
      .vid_de_i(VID_DE_I),
      .vid_ls_i(VID_LS_I),
      .vid_fs_i(VID_FS_I),
      .vid_pix_i(VID_PIX_I),
      .pix(pix_if.src),
      .ovf_o(ovf),
      .ovf_evt_o(ovf_evt)
   );

   vcs_axil u_axil (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .awaddr_i(S_AXI_AWADDR_I),
      .awvalid_i(S_AXI_AWVALID_I),
      .awready_o(S_AXI_AWREADY_O),
      .wdata_i(S_AXI_WDATA_I),
      .wstrb_i(S_AXI_WSTRB_I),
      .wvalid_i(S_AXI_WVALID_I),
      .wready_o(S_AXI_WREADY_O),
      .bresp_o(S_AXI_BRESP_O),
      .bvalid_o(S_AXI_BVALID_O),
      .bready_i(S_AXI_BREADY_I),
      .araddr_i(S_AXI_ARADDR_I),
      .arvalid_i(S_AXI_ARVALID_I),
      .arready_o(S_AXI_ARREADY_O),
      .rdata_o(S_AXI_RDATA_O),
      .rresp_o(S_AXI_RRESP_O),
      .rvalid_o(S_AXI_RVALID_O),
      .rready_i(S_AXI_RREADY_I),
      .rg(reg_if.bus)
   );

   // ********************************************************
   // Register decode
   // ********************************************************
   // Write select per register
   wire wr_ctrl = reg_if.wr_en && (reg_if.wr_addr == vcs_pkg::OFF_CTRL);
   wire wr_in = reg_if.wr_en && (reg_if.wr_addr == vcs_pkg::OFF_IN_DIM);
   wire wr_out = reg_if.wr_en && (reg_if.wr_addr == vcs_pkg::OFF_OUT_DIM);
   wire wr_mask = reg_if.wr_en && (reg_if.wr_addr == vcs_pkg::OFF_MASK);
   wire wr_ro = (reg_if.wr_addr == vcs_pkg::OFF_STATUS) ||
                (reg_if.wr_addr == vcs_pkg::OFF_STATE);
   assign reg_if.wr_err = !(wr_ctrl || wr_in || wr_out || wr_mask || wr_ro);
   // Read select and data
   wire [vcs_pkg::ADDR_W-1:0] ra = reg_if.rd_addr;
   wire rd_stat = reg_if.rd_en && (ra == vcs_pkg::OFF_STATUS);
   wire [31:0] state_word = {5'h00, LW'(lvl_ff), 13'h0000,
                             !buf_free, (st_ff == vcs_pkg::SC_SYN), ovf};
   assign reg_if.rd_data =
      (ra == vcs_pkg::OFF_CTRL) ? ctrl_ff :
      (ra == vcs_pkg::OFF_IN_DIM) ? in_dim_ff :
      (ra == vcs_pkg::OFF_OUT_DIM) ? out_dim_ff :
      (ra == vcs_pkg::OFF_STATUS) ? {29'h0000_0000, stat_ff} :
      (ra == vcs_pkg::OFF_MASK) ? {29'h0000_0000, mask_ff} :
      (ra == vcs_pkg::OFF_STATE) ? state_word : 32'h0000_0000;
   assign reg_if.rd_err = !((ra == vcs_pkg::OFF_CTRL) || (ra == vcs_pkg::OFF_IN_DIM) ||
                            (ra == vcs_pkg::OFF_OUT_DIM) || (ra == vcs_pkg::OFF_STATUS) ||
                            (ra == vcs_pkg::OFF_MASK) || (ra == vcs_pkg::OFF_STATE));
   // Events: set wins over read clear
   assign ev = {frm_evt, rsz_evt, ovf_evt};
   assign nxt_stat = (rd_stat ? '0 : stat_ff) | ev;
   assign IRQ_O = |(stat_ff & mask_ff);

   // Software registers
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         ctrl_ff <= vcs_pkg::RST_CTRL;
         in_dim_ff <= vcs_pkg::RST_IN_DIM;
         out_dim_ff <= vcs_pkg::RST_OUT_DIM;
         mask_ff <= '0;
         stat_ff <= '0;
      end else begin
         if (wr_ctrl) ctrl_ff <= vcs_pkg::vcs_merge(ctrl_ff, reg_if.wr_data, reg_if.wr_strb);
         if (wr_in) in_dim_ff <= vcs_pkg::vcs_merge(in_dim_ff, reg_if.wr_data, reg_if.wr_strb);
         if (wr_out) out_dim_ff <= vcs_pkg::vcs_merge(out_dim_ff, reg_if.wr_data, reg_if.wr_strb);
         if (wr_mask) mask_ff <= reg_if.wr_data[vcs_pkg::EV_N-1:0];
         stat_ff <= nxt_stat;
      end
   end

   // ********************************************************
   // Downscaler
   // ********************************************************
   // Scaler takes pixels while waiting, or while running with room; never while synthesizing [R3] [R7]
   assign pix_if.ready = (st_ff == vcs_pkg::SC_WAIT) ||
                         ((st_ff == vcs_pkg::SC_RUN) && buf_free);
   wire take = pix_if.valid && pix_if.ready;
   wire ls = pix_if.sof || pix_if.sol;
   // Position of the pixel now offered
   wire [DW-1:0] cur_ix = ls ? '0 : ix_ff;
   wire [DW-1:0] cur_iy = pix_if.sof ? '0 : (pix_if.sol ? DW'(iy_ff + 1'b1) : iy_ff);
   wire [DW-1:0] cur_ox = ls ? '0 : ox_ff;
   wire [DW-1:0] cur_oy = pix_if.sof ? '0 : oy_ff;
   // Line and pixel selection steps
   wire [DW:0] vstep = vcs_pkg::vcs_dda(pix_if.sof ? '0 : vacc_ff, out_h, in_h);
   wire [DW:0] hstep = vcs_pkg::vcs_dda(ls ? '0 : hacc_ff, out_w, in_w);
   wire line_sel = ls ? vstep[DW] : vsel_ff;
   wire emit = line_sel && hstep[DW];
   wire line_end = ({1'b0, cur_ix} + 1'b1) == {1'b0, in_w};
   wire frame_end = line_end && (({1'b0, cur_iy} + 1'b1) == {1'b0, in_h});
   // Short line or early frame start means a wrongly sized input
   wire mismatch = pix_if.sof || (pix_if.sol && (ix_ff != in_w));
   wire syn_last_px = ({1'b0, ox_ff} + 1'b1) == {1'b0, out_w};
   wire syn_last_ln = ({1'b0, oy_ff} + 1'b1) == {1'b0, out_h};

   // Scaler next state
   always_comb begin
      nxt_st = st_ff;
      {nxt_ix, nxt_iy, nxt_hacc, nxt_vacc} = {ix_ff, iy_ff, hacc_ff, vacc_ff};
      {nxt_ox, nxt_oy, nxt_vsel, nxt_last} = {ox_ff, oy_ff, vsel_ff, last_ff};
      nxt_cap_valid = 1'b0;
      nxt_cap_data = cap_data_ff;
      nxt_cap_sof = 1'b0;
      run_pix = 1'b0;
      rsz_evt = 1'b0;
      frm_evt = 1'b0;
      unique case (st_ff)
         vcs_pkg::SC_WAIT: begin
            // Pixels before a frame start are discarded
            run_pix = take && pix_if.sof;
         end
         vcs_pkg::SC_RUN: begin
            if (take && mismatch) begin
               nxt_st = vcs_pkg::SC_SYN; // [R2]
               rsz_evt = 1'b1;
            end else begin
               run_pix = take && (ls || (ix_ff != in_w));
            end
         end
         vcs_pkg::SC_SYN: begin
            // One made-up pixel per cycle, limited only by buffer room [R6] [R2]
            if (buf_free) begin
               nxt_cap_valid = 1'b1;
               nxt_cap_data = last_ff;
               nxt_cap_sof = (ox_ff == '0) && (oy_ff == '0);
               nxt_ox = syn_last_px ? '0 : DW'(ox_ff + 1'b1);
               nxt_oy = syn_last_px ? DW'(oy_ff + 1'b1) : oy_ff;
               if (syn_last_px && syn_last_ln) begin
                  nxt_st = vcs_pkg::SC_WAIT;
                  frm_evt = 1'b1;
               end
            end
         end
         default: nxt_st = vcs_pkg::SC_WAIT;
      endcase
      // Normal scaling of an accepted pixel
      if (run_pix) begin
         nxt_st = vcs_pkg::SC_RUN;
         nxt_ix = DW'(cur_ix + 1'b1);
         nxt_iy = cur_iy;
         nxt_hacc = hstep[DW-1:0];
         nxt_vacc = ls ? vstep[DW-1:0] : vacc_ff;
         nxt_vsel = line_sel;
         nxt_last = pix_if.data;
         nxt_ox = emit ? DW'(cur_ox + 1'b1) : cur_ox;
         nxt_oy = cur_oy;
         if (emit) begin
            nxt_cap_valid = 1'b1;
            nxt_cap_data = pix_if.data;
            nxt_cap_sof = (cur_ox == '0) && (cur_oy == '0);
         end
         if (line_end && line_sel) begin
            nxt_ox = '0;
            nxt_oy = DW'(cur_oy + 1'b1);
         end
         if (frame_end) begin
            nxt_st = vcs_pkg::SC_WAIT;
            frm_evt = 1'b1;
         end
      end
   end

   // Scaler registers
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_ff <= vcs_pkg::SC_WAIT;
         {ix_ff, iy_ff, hacc_ff, vacc_ff, ox_ff, oy_ff} <= '0;
         {vsel_ff, cap_valid_ff, cap_sof_ff} <= 3'b000;
         last_ff <= '0;
         cap_data_ff <= '0;
      end else begin
         st_ff <= sc_clr ? vcs_pkg::SC_WAIT : nxt_st; // [R8]
         {ix_ff, iy_ff, hacc_ff, vacc_ff, ox_ff, oy_ff} <=
            {nxt_ix, nxt_iy, nxt_hacc, nxt_vacc, nxt_ox, nxt_oy};
         vsel_ff <= nxt_vsel;
         last_ff <= nxt_last;
         cap_valid_ff <= nxt_cap_valid && !sc_clr;
         cap_sof_ff <= nxt_cap_sof && !sc_clr;
         cap_data_ff <= nxt_cap_data;
      end
   end

   // ********************************************************
   // Capture buffer level
   // ********************************************************
   // Words in, drain pulses out; a full buffer backs up into the parser [R4]
   wire drain_ok = DMA_DRAIN_I && (lvl_ff != '0);
   wire add_ok = nxt_cap_valid && !sc_clr;
   assign nxt_lvl = LW'(lvl_ff + LW'(add_ok) - LW'(drain_ok));
   assign CAP_DATA_O = cap_data_ff;
   assign CAP_VALID_O = cap_valid_ff;
   assign CAP_SOF_O = cap_sof_ff;

   // Level register
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         lvl_ff <= '0;
      end else begin
         lvl_ff <= nxt_lvl;
      end
   end
endmodule

// ==== dv/vcs_chk.sv ====
// Checker of bus handshakes and capture framing at the top ports.
// Assumes one clock domain; bound onto every vcs_top instance.
module vcs_chk (
   input wire logic CLK_I, RST_N_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O, S_AXI_RVALID_O, S_AXI_RREADY_I, CAP_VALID_O, CAP_SOF_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Address and data taken together, read address taken
   sequence s_wtake;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   endsequence
   sequence s_rtake;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O;
   endsequence
   a_write_answer: assert property (s_wtake |=> S_AXI_BVALID_O)
      else $error("write not answered");
   a_read_answer: assert property (s_rtake |=> S_AXI_RVALID_O)
      else $error("read not answered");
   a_write_retire: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
      else $error("write response repeated");
   a_read_retire: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
      else $error("read response repeated");
   a_read_blocked: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
      else $error("read taken while busy");
   a_write_blocked: assert property (S_AXI_BVALID_O |-> !(S_AXI_AWREADY_O || S_AXI_WREADY_O))
      else $error("write taken while busy");
   a_sof_word: assert property (CAP_SOF_O |-> CAP_VALID_O)
      else $error("frame start without word");
   a_sof_spacing: assert property (CAP_SOF_O |=> !CAP_SOF_O)
      else $error("frame shorter than two words");
endmodule
bind vcs_top vcs_chk u_vcs_chk (.*);

// ==== dv/vcs_src.sv ====
// Partner model: external video source on the capture pins.
// Assumes sampling on the rising edge; it never waits for the sink.
module vcs_src (
   input wire logic clk_i,
   output logic [23:0] pix_o = 24'h00_0000,
   output logic de_o = 1'b0,
   output logic ls_o = 1'b0,
   output logic fs_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Frame of n pixels, w per line, no backpressure honoured
   task automatic send(input int w, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         de_o <= 1'b1; fs_o <= (i == 0); ls_o <= (i % w == 0); pix_o <= 24'(i);
      end
      @(posedge clk_i);
      de_o <= 1'b0; fs_o <= 1'b0; ls_o <= 1'b0; pix_o <= ~pix_o;
   endtask
endmodule

// ==== dv/vcs_top_bench.sv ====
// Bench of the capture block: bus tasks, frames, overflow and recovery.
// Assumes vcs_src drives the video pins.
module vcs_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, x, s) begin check_count++; if ((s) !== (x)) begin n_mismatch++; \
$display("MISMATCH %s exp %h got %h", n, x, s); end end
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b1, arv = 1'b0, rr = 1'b1;
   logic drn = 1'b1, awr, wrd, bv, arr, rv, cv, sof, irq, de, ls, fs;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [3:0] stb = 4'hf;
   logic [31:0] wd = 32'h0000_0000, d, rdt;
   logic [23:0] pix, cd, cd_last;
   logic [1:0] e, brs, rre;
   int n_mismatch = 0, check_count = 0, n_words = 0, cyc = 0;
   vcs_src u_vcs_src (.clk_i(clk), .pix_o(pix), .de_o(de), .ls_o(ls), .fs_o(fs));
   vcs_top u_vcs_top (.CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
      .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(stb), .S_AXI_WVALID_I(wv),
      .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(brs), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdt),
      .S_AXI_RRESP_O(rre), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .VID_PIX_I(pix),
      .VID_DE_I(de), .VID_LS_I(ls), .VID_FS_I(fs), .CAP_DATA_O(cd), .CAP_VALID_O(cv),
      .CAP_SOF_O(sof), .DMA_DRAIN_I(drn), .IRQ_O(irq));
   // Clock, word count and run limit
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cv) begin
         n_words++;
         cd_last = cd;
      end
      if (cyc == 30000) begin n_mismatch++; tally_and_finish; end
   end
   // Bus write: both channels offered, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
      fork
         begin do @(posedge clk); while (!awr); awv <= 1'b0; end
         begin do @(posedge clk); while (!wrd); wv <= 1'b0; end
      join
      do @(posedge clk); while (!bv);
   endtask
   // Bus read, data and response taken at the answer edge
   task automatic rd(input logic [7:0] a);
      ara <= a; arv <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      d = rdt; e = rre;
   endtask
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x);
      rd(a); `CHK(n, x, d)
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Register defaults, frames, overflow, recovery
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc("in_dim", 8'h04, 32'h0004_0004);
      rc("out_dim", 8'h08, 32'h0002_0002);
      rd(8'h20); `CHK("resp", 2'h2, e)
      wr(8'h10, 32'h0000_0007); wr(8'h00, 32'h0000_0001);
      u_vcs_src.send(4, 16); repeat (40) @(posedge clk);
      `CHK("words", 4, n_words)
      `CHK("data", 24'h00_000f, cd_last)
      `CHK("irq", 1'b1, irq)
      rc("status", 8'h0c, 32'h0000_0004);
      `CHK("irq", 1'b0, irq)
      n_words = 0; u_vcs_src.send(4, 6); u_vcs_src.send(4, 16); repeat (40) @(posedge clk);
      `CHK("words", 4, n_words)
      `CHK("data", 24'h00_0005, cd_last)
      rc("status", 8'h0c, 32'h0000_0007);
      wr(8'h04, 32'h0020_0020); wr(8'h08, 32'h0020_0020); drn <= 1'b0; n_words = 0;
      u_vcs_src.send(32, 1024); u_vcs_src.send(32, 4); repeat (40) @(posedge clk);
      `CHK("words", 1024, n_words)
      rc("state", 8'h14, 32'h0400_0005);
      `CHK("irq", 1'b1, irq)
      wr(8'h10, 32'h0000_0000); `CHK("irq", 1'b0, irq)
      drn <= 1'b1; repeat (1100) @(posedge clk);
      u_vcs_src.send(32, 40); repeat (20) @(posedge clk);
      rc("state", 8'h14, 32'h0000_0000);
      wr(8'h00, 32'h0000_0000); wr(8'h00, 32'h0000_0002);
      wr(8'h00, 32'h0000_0006); repeat (20) @(posedge clk);
      wr(8'h00, 32'h0000_0004); wr(8'h00, 32'h0000_0000); wr(8'h00, 32'h0000_0001);
      n_words = 0; u_vcs_src.send(32, 1024); repeat (40) @(posedge clk);
      `CHK("words", 1024, n_words)
      tally_and_finish;
   end
endmodule
